/* File: hdl/mis_edge_det.sv */
// Selectable single-edge detector for a synchronous input.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ps
module mis_edge_det (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Sampled signal and edge select
   input  wire logic din,
   input  wire logic rising,
   // Edge pulse
   output logic      edge_hit
);
   typedef struct packed {
      logic prev;
      logic armed;
   } mis_ed_state_t;
   mis_ed_state_t s_q, s_d;

   // Remember last level
   always_comb begin
      s_d      = s_q;
      s_d.prev = din;
      s_d.armed = 1'b1;                // First sample after reset is only a reference
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Only the chosen direction counts; no false edge right after reset
   assign edge_hit = s_q.armed & (rising ? (din & ~s_q.prev) : (~din & s_q.prev));
endmodule : mis_edge_det

/* File: hdl/mis_irq_src.sv */
// Interrupt source logic: external pin, timer overflow, port change.
// Assumes a plain register port and synchronous pin inputs.
//
// Overview of operation
// (R1) Pin edge direction follows option bit six
// (R2) Selected pin edge sets external flag
// (R3) Clear external enable blocks pin interrupt
// (R4) Software clears external flag before re-enabling
// (R5) Pin edge wakes sleep if enabled before
// (R6) After wake, vector only when global enabled
// (R7) Timer rollover to zero sets overflow flag
// (R8) Timer enable bit gates overflow interrupt
// (R9) Change on port pins 7-4 sets flag
// (R10) Port change has its own enable bit
// (R11) Change during port read may miss
// (R12) Request when flag, enable and global set
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mis_irq_src
   import mis_pkg::*;
#(
   parameter int PORT_W = 8
) (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_N,
   // Register port
   input  wire logic [3:0]        ADDR,
   input  wire logic [7:0]        WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic [7:0]             RDATA,
   // Pins
   input  wire logic              EXT_IRQ_PIN,
   input  wire logic [PORT_W-1:0] PORT_B_PINS,
   // Core interface
   input  wire logic              TIMER_TICK,
   input  wire logic              SLEEP_REQ,
   output logic                   IRQ_REQ,
   output logic                   WAKE,
   output logic                   VECTOR
);
   import mis_pkg::*;

   typedef struct packed {
      logic [7:0]        ctrl;
      logic [7:0]        option;
      logic [7:0]        timer;
      logic              pce;
      logic [3:0]        port_last;
      logic              port_seen;
      logic              port_rd;
      mis_core_t         core;
      logic              sleep_ext_en;
      logic              wake;
      logic              vector;
      logic              irq;
      logic [7:0]        rdata;
   } mis_state_t;

   mis_state_t s_q, s_d;
   logic [1:0] rst_sync_q;
   logic       rst_n_i;
   logic [1:0] phase;
   logic       ext_edge;

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_i = rst_sync_q[1];

   // Internal phase strobes
   mis_phase_gen u_phase (
      .clk       (CLK),
      .rst_n     (rst_n_i),
      .phase     (phase),
      .cycle_end ()
   );

   // External pin edge detector
   mis_edge_det u_edge (
      .clk      (CLK),
      .rst_n    (rst_n_i),
      .din      (EXT_IRQ_PIN),
      .rising   (s_q.option[MIS_BIT_EDGE]),   // see (R1)
      .edge_hit (ext_edge)
   );

   // Register read mux
   function automatic logic [7:0] rd_mux(input mis_state_t s, input logic [3:0] a,
                                         input logic [3:0] pins);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         MIS_ADDR_IRQ_CTRL: v = s.ctrl;
         MIS_ADDR_OPTION:   v = s.option;
         MIS_ADDR_TIMER:    v = s.timer;
         MIS_ADDR_PORT:     v = {pins, 4'h0};
         MIS_ADDR_PORT_CHANGE_ENABLE:     v = {7'h00, s.pce};
         MIS_ADDR_CORE:     v = {5'h00, s.vector, s.wake, s.core == MIS_ASLEEP};
         default:           v = 8'h00;
      endcase
      return v;
   endfunction : rd_mux

   // Next-state logic
   always_comb begin
      logic [3:0] hi_pins;
      logic       port_chg;
      logic       pend;
      hi_pins  = PORT_B_PINS[PORT_W-1 -: 4];
      port_chg = 1'b0;
      pend     = 1'b0;
      s_d      = s_q;
      s_d.wake   = 1'b0;
      s_d.vector = 1'b0;
      s_d.rdata  = 8'h00;

      // Register writes first, so hardware sets below win over clears
      if (WR) begin
         unique case (ADDR)
            MIS_ADDR_IRQ_CTRL: s_d.ctrl   = WDATA;
            MIS_ADDR_OPTION:   s_d.option = WDATA;
            MIS_ADDR_TIMER:    s_d.timer  = WDATA;
            MIS_ADDR_PORT_CHANGE_ENABLE:     s_d.pce    = WDATA[0];   // see (R10)
            default: ;
         endcase
      end
      if (RD) begin
         s_d.rdata = rd_mux(s_q, ADDR, hi_pins);
      end

      // Timer counts on tick; rollover sets overflow flag
      if (TIMER_TICK && !(WR && ADDR == MIS_ADDR_TIMER)) begin
         s_d.timer = s_q.timer + 8'h01;
         if (s_q.timer == MIS_TIMER_MAX) begin
            s_d.ctrl[MIS_BIT_TOVF] = 1'b1;            // see (R7)
         end
      end

      // Pin edge sets the external flag
      if (ext_edge) begin
         s_d.ctrl[MIS_BIT_EXTF] = 1'b1;               // see (R2)
      end

      // Port change; a change seen during a phase-two read is held off to the next cycle, as port_last keeps its old value
      s_d.port_rd = RD && (ADDR == MIS_ADDR_PORT);
      // No change is reported until one reference sample has been taken
      s_d.port_seen = 1'b1;
      port_chg    = s_q.port_seen && (hi_pins != s_q.port_last);   // see (R9)
      if (port_chg && !(s_q.port_rd && phase == MIS_PHASE_READ)) begin
         s_d.ctrl[MIS_BIT_PCF] = 1'b1;                // see (R11)
      end
      if (!(s_q.port_rd && phase == MIS_PHASE_READ)) begin
         s_d.port_last = hi_pins;
      end

      // Combined request; flags are never cleared by hardware
      pend = (s_q.ctrl[MIS_BIT_EXTF] & s_q.ctrl[MIS_BIT_EXTE])    // see (R3) (R4)
           | (s_q.ctrl[MIS_BIT_TOVF] & s_q.ctrl[MIS_BIT_TIE])     // see (R8)
           | (s_q.ctrl[MIS_BIT_PCF]  & s_q.pce);                  // see (R10)
      s_d.irq = pend & s_q.ctrl[MIS_BIT_GIE];                     // see (R12)

      // Sleep and wake sequencing
      unique case (s_q.core)
         MIS_AWAKE: begin
            if (SLEEP_REQ) begin
               s_d.core         = MIS_ASLEEP;
               s_d.sleep_ext_en = s_q.ctrl[MIS_BIT_EXTE];
            end
         end
         MIS_ASLEEP: begin
            if (s_q.sleep_ext_en && s_q.ctrl[MIS_BIT_EXTE] &&
                s_q.ctrl[MIS_BIT_EXTF]) begin
               s_d.core = MIS_WOKEN;                  // see (R5)
               s_d.wake = 1'b1;
            end
         end
         MIS_WOKEN: begin
            s_d.core   = MIS_AWAKE;
            s_d.vector = s_q.ctrl[MIS_BIT_GIE];        // see (R6)
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q              <= '0;
         s_q.ctrl         <= MIS_RST_IRQ_CTRL;
         s_q.option       <= MIS_RST_OPTION;
         s_q.timer        <= MIS_RST_TIMER;
         s_q.core         <= MIS_AWAKE;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA   = s_q.rdata;
   assign IRQ_REQ = s_q.irq;
   assign WAKE    = s_q.wake;
   assign VECTOR  = s_q.vector;
endmodule : mis_irq_src

/* File: hdl/mis_phase_gen.sv */
// Four-phase generator giving one-cycle phase strobes.
// Assumes active-low reset from the top module, asserted asynchronously and released in step with the clock.
`timescale 1ns/1ps
module mis_phase_gen
   import mis_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Phase outputs
   output logic [1:0]      phase,
   output logic            cycle_end
);
   typedef struct packed {
      logic [1:0] ph;
   } mis_ph_state_t;
   mis_ph_state_t s_q, s_d;

   // Count through the four phases
   always_comb begin
      s_d    = s_q;
      s_d.ph = s_q.ph + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign phase     = s_q.ph;
   assign cycle_end = (s_q.ph == 2'(MIS_PHASES - 1));
endmodule : mis_phase_gen

/* File: inc/mis_pkg.sv */
// Constants and types for the interrupt source block.
// Assumes a single 25 MHz core clock and a plain register port.
package mis_pkg;
   // Register offsets (bus address is word index)
   localparam logic [3:0] MIS_ADDR_IRQ_CTRL = 4'h0;  // irq_control_reg
   localparam logic [3:0] MIS_ADDR_OPTION   = 4'h1;  // option register
   localparam logic [3:0] MIS_ADDR_TIMER    = 4'h2;  // timer_count_reg
   localparam logic [3:0] MIS_ADDR_PORT     = 4'h3;  // port_b_pins read
   localparam logic [3:0] MIS_ADDR_PORT_CHANGE_ENABLE     = 4'h4;  // port_change_enable
   localparam logic [3:0] MIS_ADDR_CORE     = 4'h5;  // sleep / wake status
   // Field positions in irq_control_reg
   localparam int MIS_BIT_PCF  = 0;  // port_change_flag
   localparam int MIS_BIT_EXTF = 1;  // ext_irq_flag
   localparam int MIS_BIT_TOVF = 2;  // timer_overflow_flag
   localparam int MIS_BIT_EXTE = 4;  // ext_irq_enable
   localparam int MIS_BIT_TIE  = 5;  // timer_irq_enable
   localparam int MIS_BIT_GIE  = 7;  // global_irq_enable
   // Field positions in option register
   localparam int MIS_BIT_EDGE = 6;  // ext_edge_select
   // Field positions in core register
   localparam int MIS_BIT_SLEEP = 0;
   localparam int MIS_BIT_WAKE  = 1;
   localparam int MIS_BIT_VEC   = 2;
   // Reset values and timer maximum
   localparam logic [7:0] MIS_RST_IRQ_CTRL = 8'h00;
   localparam logic [7:0] MIS_RST_OPTION   = 8'hff;
   localparam logic [7:0] MIS_RST_TIMER    = 8'h00;
   localparam logic [7:0] MIS_TIMER_MAX    = 8'hff;
   // Internal phase count per instruction cycle
   localparam int         MIS_PHASES       = 4;
   localparam logic [1:0] MIS_PHASE_READ   = 2'h1;  // second phase
   typedef enum logic [1:0] {MIS_AWAKE, MIS_ASLEEP, MIS_WOKEN} mis_core_t;
endpackage : mis_pkg

/* File: sim/mcu_interrupt_sources_tb.sv */
// Self-checking bench for the interrupt source block.
// Assumes the pin model and bound checker are compiled alongside.
`timescale 1ns/1ps
module mcu_interrupt_sources_tb;
   logic       CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
   logic       TIMER_TICK = 1'b0, SLEEP_REQ = 1'b0, ext = 1'b0;
   logic       EXT_IRQ_PIN, IRQ_REQ, WAKE, VECTOR;
   logic [3:0] ADDR = 4'h0, hi = 4'h0;
   logic [7:0] WDATA = 8'h00, RDATA, PORT_B_PINS;
   int         mismatches = 0, tests_run = 0, cyc = 0;
   always #20 CLK = ~CLK;
   mis_irq_src u_mis_irq_src (.CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_IRQ_PIN,
      .PORT_B_PINS, .TIMER_TICK, .SLEEP_REQ, .IRQ_REQ, .WAKE, .VECTOR);
   mis_pin_model u_mis_pin_model (.clk(CLK), .ext_lvl(ext), .hi_lvl(hi),
      .ext_pin(EXT_IRQ_PIN), .port_pins(PORT_B_PINS));
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset;
      RST_N <= 1'b0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
   endtask : do_reset
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
   endtask : rd
   task automatic pin(input logic e, input logic [3:0] h);
      @(posedge CLK);
      ext <= e;
      hi <= h;
   endtask : pin
   // Let a cause settle, then look at the request line
   task automatic irq(input logic e);
      repeat (4) @(posedge CLK);
      #1 chk({7'h00, IRQ_REQ}, {7'h00, e});
   endtask : irq
   task automatic tick;
      @(posedge CLK);
      TIMER_TICK <= 1'b1;
      @(posedge CLK);
      TIMER_TICK <= 1'b0;
   endtask : tick
   task automatic t_regs;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'hff);
      rd(4'h2, 8'h00);
      wr(4'hf, 8'h55);
      rd(4'hf, 8'h00);
   endtask : t_regs
   task automatic t_ext(input logic r);
      wr(4'h1, {1'b1, r, 6'h3f});
      pin(!r, hi);
      irq(1'b0);
      wr(4'h0, 8'h80);
      pin(r, hi);
      irq(1'b0);
      rd(4'h0, 8'h82);
      wr(4'h0, 8'h80);
      wr(4'h0, 8'h90);
      pin(!r, hi);
      irq(1'b0);
      pin(r, hi);
      irq(1'b1);
      wr(4'h0, 8'h00);
   endtask : t_ext
   task automatic t_timer;
      wr(4'h0, 8'ha0);
      wr(4'h2, 8'hfe);
      tick;
      irq(1'b0);
      rd(4'h2, 8'hff);
      tick;
      irq(1'b1);
      rd(4'h0, 8'ha4);
      rd(4'h2, 8'h00);
      wr(4'h0, 8'h84);
      irq(1'b0);
   endtask : t_timer
   task automatic t_port;
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h80);
      irq(1'b0);
      pin(ext, 4'h5);
      irq(1'b1);
      rd(4'h3, 8'h50);
      rd(4'h0, 8'h81);
      wr(4'h4, 8'h00);
      irq(1'b0);
   endtask : t_port
   task automatic t_sleep(input logic [7:0] ctl, input logic late, input logic [1:0] e);
      logic w = 1'b0;
      logic v = 1'b0;
      do_reset;
      pin(1'b0, hi);
      wr(4'h0, ctl);
      @(posedge CLK);
      SLEEP_REQ <= 1'b1;
      @(posedge CLK);
      SLEEP_REQ <= 1'b0;
      if (late) wr(4'h0, 8'h10);
      pin(1'b1, hi);
      repeat (8) begin
         @(posedge CLK);
         #1 w |= WAKE;
         v |= VECTOR;
      end
      chk({6'h00, w, v}, {6'h00, e});
      rd(4'h5, {7'h00, ~e[1]});
   endtask : t_sleep
   // Main sequence
   initial begin
      do_reset;
      t_regs;
      t_ext(1'b0);
      t_ext(1'b1);
      t_timer;
      t_port;
      t_sleep(8'h90, 1'b0, 2'b11);
      t_sleep(8'h10, 1'b0, 2'b10);
      t_sleep(8'h00, 1'b1, 2'b00);
      report_and_stop;
   end
endmodule : mcu_interrupt_sources_tb

/* File: sim/mis_irq_src_sva.sv */
// Port checker for the interrupt source block.
// Assumes it is bound to mis_irq_src and sees only its ports.
`timescale 1ns/1ps
module mis_irq_src_sva #(
   parameter int PORT_W = 8
) (
   // Clock, reset and register port
   input wire logic              CLK, RST_N, WR, RD,
   input wire logic [3:0]        ADDR,
   input wire logic [7:0]        WDATA, RDATA,
   // Pins and core side
   input wire logic              EXT_IRQ_PIN, TIMER_TICK, SLEEP_REQ,
   input wire logic [PORT_W-1:0] PORT_B_PINS,
   input wire logic              IRQ_REQ, WAKE, VECTOR
);
   logic [7:0] ic_q, tm_q;
   logic       ed_q, pe_q, ok;
   // Shadow of software-owned enables, edge select and timer count
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ic_q <= 8'h00;
         tm_q <= 8'h00;
         ed_q <= 1'b1;
         pe_q <= 1'b0;
      end else begin
         if (WR && ADDR == 4'h0) ic_q <= WDATA;
         if (WR && ADDR == 4'h1) ed_q <= WDATA[6];
         if (WR && ADDR == 4'h4) pe_q <= WDATA[0];
         if (WR && ADDR == 4'h2) tm_q <= WDATA;
         else if (TIMER_TICK) tm_q <= tm_q + 8'h01;
      end
   end
   assign ok = ic_q[7] && (ic_q[4] || ic_q[5] || pe_q);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Selected pin edge, and a request that follows soon after
   sequence s_pin_edge;
      ed_q ? $rose(EXT_IRQ_PIN) : $fell(EXT_IRQ_PIN);
   endsequence
   sequence s_req_soon;
      ##[1:4] IRQ_REQ;
   endsequence
   property p_ext_edge;
      s_pin_edge ##0 (ic_q[4] && ic_q[7]) |-> s_req_soon;
   endproperty
   property p_req_cause;
      IRQ_REQ |-> ok || $past(ok);
   endproperty
   property p_timer;
      TIMER_TICK && tm_q == 8'hff && ic_q[5] && ic_q[7] |-> s_req_soon;
   endproperty
   property p_port;
      $changed(PORT_B_PINS[7:4]) && pe_q && ic_q[7] && !RD && !$past(RD) |-> s_req_soon;
   endproperty
   property p_wake_pulse;
      WAKE |=> !WAKE;
   endproperty
   property p_wake_en;
      WAKE |-> ic_q[4] || $past(ic_q[4]);
   endproperty
   property p_vec;
      WAKE && ic_q[7] |=> VECTOR;
   endproperty
   property p_no_vec;
      VECTOR |-> $past(WAKE) && $past(ic_q[7]);
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("pin edge gave no request");
   a_req_cause: assert property (p_req_cause) else $error("request without cause");
   a_timer: assert property (p_timer) else $error("rollover gave no request");
   a_port: assert property (p_port) else $error("port change gave no request");
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
   a_wake_en: assert property (p_wake_en) else $error("wake while disabled");
   a_vec: assert property (p_vec) else $error("vector missing");
   a_no_vec: assert property (p_no_vec) else $error("vector unexpected");
endmodule : mis_irq_src_sva

bind mis_irq_src mis_irq_src_sva #(.PORT_W(PORT_W)) u_mis_irq_src_sva (.CLK, .RST_N, .WR,
   .RD, .ADDR, .WDATA, .RDATA, .EXT_IRQ_PIN, .TIMER_TICK, .SLEEP_REQ, .PORT_B_PINS,
   .IRQ_REQ, .WAKE, .VECTOR);

/* File: sim/mis_pin_model.sv */
// Pin-side model: external interrupt pin and port pins.
// Assumes the bench requests levels; low nibble churns every cycle.
`timescale 1ns/1ps
module mis_pin_model (
   // Clock and requested levels
   input  wire logic       clk,
   input  wire logic       ext_lvl,
   input  wire logic [3:0] hi_lvl,
   // Pins
   output logic            ext_pin = 1'b0,
   output logic [7:0]      port_pins = 8'h00
);
   logic [3:0] lo_q = 4'h0;
   // Pins follow requests one edge later
   always_ff @(posedge clk) begin
      ext_pin   <= ext_lvl;
      lo_q      <= lo_q + 4'h1;
      port_pins <= {hi_lvl, lo_q};
   end
endmodule : mis_pin_model
